// ===== design/mq_read_pkg.sv
// Summary of operation
// - Read enable low pops next word out
// - Queue strobe high captures new read selection
// - Eight-bit address, low four bits pick queue
// - Address bit four picks the null queue
// - Top three bits must match device identity
// - Capture edge may still output old queue
// - First edge after select: old queue word
// - Second edge after select: new queue head
// - Selection accepted whatever the read enable
// - Sector select uses bit zero, ignores 4:1
// - Sector strobe captures sector, drives its status
// - Flag bus needs no read enable
// - Polled mode steps sectors, sync on clock
// - Queue flags updated on the read clock
// - Expansion out/in timed by read clock
// - Drive data only when enabled and selected
package mq_read_pkg;
  // Data path and address layout
  localparam int DATA_WIDTH = 36;
  localparam int ADDR_BUS_W = 8;
  localparam int QUEUES = 16;
  localparam int QSEL_W = 4;
  localparam int QSEL_MSB = 3;
  localparam int NULL_BIT = 4;
  localparam int ID_LSB = 5;
  localparam int ID_MSB = 7;
  localparam int ID_W = 3;
  localparam int SECTOR_BIT = 0;
  localparam int SECTOR_W = 8;
  localparam int DEPTH_LOG2_DEFAULT = 6;
  localparam int SYNC_W = 14;
  // Register map, byte addresses on a 32-bit word bus
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 32;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_THRESH = 4'h8;
  // Control word fields
  localparam int CTRL_POLLED_BIT = 0;
  localparam int CTRL_ID_LSB = 1;
  localparam int CTRL_ID_MSB = 3;
  localparam int CTRL_PROG_DONE_BIT = 4;
  // Status word fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_SEL_BIT = 1;
  localparam int STAT_NULL_BIT = 2;
  localparam int STAT_Q_LSB = 4;
  localparam int STAT_Q_MSB = 7;
  // Threshold word fields and reset values
  localparam int THR_W = 8;
  localparam int THR_AE_LSB = 0;
  localparam int THR_AE_MSB = 7;
  localparam int THR_PKT_LSB = 8;
  localparam int THR_PKT_MSB = 15;
  localparam logic [7:0] AE_THRESH_RESET = 8'h02;
  localparam logic [7:0] PKT_SIZE_RESET = 8'h04;
  localparam logic [2:0] DEV_ID_RESET = 3'h0;
  // Queue change sequence
  typedef enum logic [1:0] {PH_IDLE, PH_LOAD_OLD, PH_LOAD_NEW} phase_type;
endpackage

// ===== design/queue_mem_if.sv
`timescale 1ns/1ps
interface queue_mem_if #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 36
);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// ===== design/queue_store.sv
`timescale 1ns/1ps
module queue_store #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 36
) (
  input wire logic clk,
  input wire logic ce,
  queue_mem_if.mem port
);
  logic [DATA_W-1:0] store [2**ADDR_W];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (ce) begin
      if (port.wr_en) begin
        store[port.wr_addr] <= port.wr_data;
      end
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule

// ===== design/sector_flag_unit.sv
`timescale 1ns/1ps
module sector_flag_unit
  import mq_read_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic polled,
  input wire logic strobe_hit,
  input wire logic sector_addr,
  input wire logic [QUEUES-1:0] ae_n,
  output logic [SECTOR_W-1:0] status_n,
  output logic poll_sync
);
  logic sector;
  logic [SECTOR_W-1:0] shown;

  // Status of the sector in view
  assign shown = sector ? ae_n[QUEUES-1:SECTOR_W] : ae_n[SECTOR_W-1:0];

  // Sector pointer, status bus and poll sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sector <= 1'b0;
      status_n <= '1;
      poll_sync <= 1'b0;
    end else if (ce) begin
      if (polled) begin
        sector <= ~sector;
      end else if (strobe_hit) begin
        sector <= sector_addr;
      end
      status_n <= shown;
      poll_sync <= polled && !sector;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_direct_sector;
    ce && !polled && strobe_hit |=> sector == $past(sector_addr);
  endproperty
  a_direct_sector: assert property (p_direct_sector)
    else $error("strobed sector not captured");

  property p_direct_status;
    (ce && !polled && strobe_hit) ##1 (ce && !polled && !strobe_hit) |=>
      status_n == ($past(sector_addr, 2) ? $past(ae_n[QUEUES-1:SECTOR_W])
                                         : $past(ae_n[SECTOR_W-1:0]));
  endproperty
  a_direct_status: assert property (p_direct_status)
    else $error("status bus does not show strobed sector");

  property p_poll_step;
    (ce && polled) ##1 ce |-> sector != $past(sector);
  endproperty
  a_poll_step: assert property (p_poll_step)
    else $error("polled sector did not step");

  property p_poll_sync;
    (ce && polled) [*3] |-> poll_sync != $past(poll_sync);
  endproperty
  a_poll_sync: assert property (p_poll_sync)
    else $error("poll sync not alternating");
endmodule

// ===== design/multi_queue_read_port.sv
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module multi_queue_read_port
  import mq_read_pkg::*;
#(
  parameter int DEPTH_LOG2 = DEPTH_LOG2_DEFAULT,
  parameter int DATA_W = DATA_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic read_en_n,
  input wire logic out_enable_n,
  input wire logic queue_select_strobe,
  input wire logic flag_sector_strobe,
  input wire logic [ADDR_BUS_W-1:0] read_address_bus,
  input wire logic program_enable_in_n,
  input wire logic expansion_in,
  output logic [DATA_W-1:0] read_data,
  output logic read_data_oe_n,
  output logic almost_empty_flag_n,
  output logic packet_ready_flag_n,
  output logic output_valid_flag_n,
  output logic [SECTOR_W-1:0] sector_status_bus_n,
  output logic flag_poll_sync,
  output logic expansion_out,
  output logic program_done_out_n,
  input wire logic write_valid,
  input wire logic [QSEL_W-1:0] write_queue,
  input wire logic [DATA_W-1:0] write_data,
  output logic write_ready,
  input wire logic [BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BUS_DATA_W-1:0] avs_writedata,
  output logic [BUS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int PTR_W = DEPTH_LOG2 + 1;
  localparam int MEM_AW = QSEL_W + DEPTH_LOG2;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic s_ren_n;
  logic s_oe_n;
  logic s_qstrobe;
  logic s_fstrobe;
  logic s_prog_en_n;
  logic s_exp_in;
  logic [ADDR_BUS_W-1:0] s_addr;
  logic polled;
  logic prog_done;
  logic [ID_W-1:0] dev_id;
  logic [THR_W-1:0] ae_thresh;
  logic [THR_W-1:0] pkt_size;
  logic bus_ack;
  logic [BUS_DATA_W-1:0] read_word;
  logic [BUS_DATA_W-1:0] ctrl_word;
  logic [BUS_DATA_W-1:0] status_word;
  logic [BUS_DATA_W-1:0] thresh_word;
  logic bus_wr;
  phase_type phase;
  logic [QSEL_W-1:0] cur_q;
  logic [QSEL_W-1:0] pend_q;
  logic cur_null;
  logic pend_null;
  logic selected;
  logic out_valid;
  logic id_match;
  logic sel_hit;
  logic sector_hit;
  logic pop;
  logic cur_avail;
  logic wr_go;
  logic bump;
  logic [QSEL_W-1:0] next_q;
  logic [PTR_W-1:0] head_ptr;
  logic [PTR_W-1:0] wr_ptr [QUEUES];
  logic [PTR_W-1:0] wr_seen [QUEUES];
  logic [PTR_W-1:0] rd_ptr [QUEUES];
  logic [PTR_W-1:0] avail [QUEUES];
  logic [QUEUES-1:0] full;
  logic [QUEUES-1:0] ae_n;
  logic [QUEUES-1:0] wr_hit;
  logic [QUEUES-1:0] rd_hit;

  queue_mem_if #(.ADDR_W(MEM_AW), .DATA_W(DATA_W)) mem_if ();

  queue_store #(.ADDR_W(MEM_AW), .DATA_W(DATA_W)) u_store (
    .clk(clk),
    .ce(ce),
    .port(mem_if.mem)
  );

  // Pin synchroniser, second stage is the only reader of the first
  assign pins_raw = {read_en_n, out_enable_n, queue_select_strobe, flag_sector_strobe,
                     program_enable_in_n, expansion_in, read_address_bus};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce) begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end
  assign {s_ren_n, s_oe_n, s_qstrobe, s_fstrobe, s_prog_en_n, s_exp_in, s_addr} = sync_b;

  assign id_match = s_addr[ID_MSB:ID_LSB] == dev_id;
  assign sel_hit = s_qstrobe && id_match;
  assign sector_hit = s_fstrobe && id_match;

  // Per-queue pointers and fill state
  genvar gi;
  generate
    for (gi = 0; gi < QUEUES; gi++) begin : g_queue
      assign wr_hit[gi] = wr_go && (write_queue == QSEL_W'(gi));
      assign rd_hit[gi] = pop && !cur_null && (cur_q == QSEL_W'(gi));
      assign avail[gi] = wr_seen[gi] - rd_ptr[gi];
      assign full[gi] = (wr_ptr[gi] - rd_ptr[gi]) == PTR_W'(2**DEPTH_LOG2);
      assign ae_n[gi] = !(int'(avail[gi]) <= int'(ae_thresh));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wr_ptr[gi] <= '0;
          wr_seen[gi] <= '0;
          rd_ptr[gi] <= '0;
        end else if (ce) begin
          if (wr_hit[gi]) begin
            wr_ptr[gi] <= wr_ptr[gi] + 1'b1;
          end
          wr_seen[gi] <= wr_ptr[gi]; // Hides a word until its store write lands
          if (rd_hit[gi]) begin
            rd_ptr[gi] <= rd_ptr[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Write side of the store
  assign write_ready = !full[write_queue];
  assign wr_go = write_valid && write_ready;
  assign mem_if.wr_en = wr_go;
  assign mem_if.wr_addr = {write_queue, wr_ptr[write_queue][DEPTH_LOG2-1:0]};
  assign mem_if.wr_data = write_data;

  // Pop decision per phase of a queue change
  assign cur_avail = !cur_null && (avail[cur_q] != '0);
  always_comb begin
    case (phase)
      PH_LOAD_OLD: pop = cur_avail;
      PH_LOAD_NEW: pop = cur_avail;
      // pop on read enable or empty output
      PH_IDLE: pop = cur_avail && (!out_valid || !s_ren_n);
      default: pop = 1'b0;
    endcase
  end

  // Prefetch address, new queue head fetched during the old-word edge
  assign next_q = (phase == PH_LOAD_OLD) ? pend_q : cur_q;
  assign bump = pop && (next_q == cur_q);
  assign head_ptr = rd_ptr[next_q] + PTR_W'(bump);
  assign mem_if.rd_addr = {next_q, head_ptr[DEPTH_LOG2-1:0]};

  // Queue selection and change sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      pend_q <= '0;
      pend_null <= 1'b1;
      cur_q <= '0;
      cur_null <= 1'b1;
      selected <= 1'b0;
    end else if (ce) begin
      if (sel_hit) begin
        pend_q <= s_addr[QSEL_MSB:0];
        pend_null <= s_addr[NULL_BIT];
        selected <= 1'b1;
        phase <= PH_LOAD_OLD;
      end else begin
        case (phase)
          PH_LOAD_OLD: phase <= PH_LOAD_NEW;
          PH_LOAD_NEW: phase <= PH_IDLE;
          PH_IDLE: phase <= PH_IDLE;
          default: phase <= PH_IDLE;
        endcase
      end
      if (phase == PH_LOAD_OLD) begin
        cur_q <= pend_q;
        cur_null <= pend_null;
      end
    end
  end

  // output register, old queue may still read on capture edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data <= '0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (pop) begin
        read_data <= mem_if.rd_data;
        out_valid <= 1'b1;
      end else if (!s_ren_n || phase != PH_IDLE) begin
        out_valid <= 1'b0;
      end
    end
  end

  // drive only when enabled, selected, no other device driving
  assign read_data_oe_n = !(!s_ren_n && !s_oe_n && selected && !cur_null && !s_exp_in);

  // queue flags and expansion out on the read clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      almost_empty_flag_n <= 1'b1;
      packet_ready_flag_n <= 1'b1;
      expansion_out <= 1'b0;
      program_done_out_n <= 1'b1;
    end else if (ce) begin
      almost_empty_flag_n <= !cur_null && ae_n[cur_q];
      packet_ready_flag_n <= cur_null || (int'(avail[cur_q]) < int'(pkt_size));
      expansion_out <= selected && !cur_null && out_valid;
      program_done_out_n <= !(prog_done && !s_prog_en_n);
    end
  end
  assign output_valid_flag_n = !out_valid;

  sector_flag_unit u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .polled(polled),
    .strobe_hit(sector_hit),
    .sector_addr(s_addr[SECTOR_BIT]),
    .ae_n(ae_n),
    .status_n(sector_status_bus_n),
    .poll_sync(flag_poll_sync)
  );

  // Register bus, one wait cycle, held while frozen so no access is lost
  assign avs_waitrequest = (avs_read || avs_write) && !(bus_ack && ce);
  assign bus_wr = avs_write && bus_ack;
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_POLLED_BIT] = polled;
    ctrl_word[CTRL_ID_MSB:CTRL_ID_LSB] = dev_id;
    ctrl_word[CTRL_PROG_DONE_BIT] = prog_done;
    status_word = '0;
    status_word[STAT_VALID_BIT] = out_valid;
    status_word[STAT_SEL_BIT] = selected;
    status_word[STAT_NULL_BIT] = cur_null;
    status_word[STAT_Q_MSB:STAT_Q_LSB] = cur_q;
    thresh_word = '0;
    thresh_word[THR_AE_MSB:THR_AE_LSB] = ae_thresh;
    thresh_word[THR_PKT_MSB:THR_PKT_LSB] = pkt_size;
  end
  assign read_word = (avs_address == OFS_CTRL) ? ctrl_word :
                     (avs_address == OFS_STATUS) ? status_word :
                     (avs_address == OFS_THRESH) ? thresh_word : '0;

  // Bus handshake and register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= '0;
      polled <= 1'b0;
      dev_id <= DEV_ID_RESET;
      prog_done <= 1'b0;
      ae_thresh <= AE_THRESH_RESET;
      pkt_size <= PKT_SIZE_RESET;
    end else if (ce) begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= read_word;
      end
      if (bus_wr && avs_address == OFS_CTRL) begin
        polled <= avs_writedata[CTRL_POLLED_BIT];
        dev_id <= avs_writedata[CTRL_ID_MSB:CTRL_ID_LSB];
        prog_done <= avs_writedata[CTRL_PROG_DONE_BIT];
      end
      if (bus_wr && avs_address == OFS_THRESH) begin
        ae_thresh <= avs_writedata[THR_AE_MSB:THR_AE_LSB];
        pkt_size <= avs_writedata[THR_PKT_MSB:THR_PKT_LSB];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_capture;
    ce && sel_hit |=> phase == PH_LOAD_OLD && pend_q == $past(s_addr[QSEL_MSB:0]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("queue selection not captured");

  property p_null_bit;
    ce && sel_hit |=> pend_null == $past(s_addr[NULL_BIT]);
  endproperty
  a_null_bit: assert property (p_null_bit)
    else $error("null queue bit not captured");

  property p_any_ren;
    ce && sel_hit && s_ren_n |=> phase == PH_LOAD_OLD;
  endproperty
  a_any_ren: assert property (p_any_ren)
    else $error("selection refused with read enable high");

  property p_old_word;
    ce && phase == PH_LOAD_OLD && !sel_hit && cur_avail |=>
      out_valid && read_data == $past(mem_if.rd_data) && cur_q == $past(pend_q);
  endproperty
  a_old_word: assert property (p_old_word)
    else $error("previous queue word missing after selection");

  property p_new_head;
    (ce && sel_hit) ##1 (ce && !sel_hit) ##1 (ce && cur_avail) |=>
      out_valid && phase == PH_IDLE && read_data == $past(mem_if.rd_data);
  endproperty
  a_new_head: assert property (p_new_head)
    else $error("new queue head missing two edges after selection");

  property p_read;
    ce && phase == PH_IDLE && !sel_hit && !s_ren_n && cur_avail |=>
      out_valid && read_data == $past(mem_if.rd_data);
  endproperty
  a_read: assert property (p_read)
    else $error("enabled read did not present next word");

  property p_null_hold;
    cur_null |-> rd_hit == '0;
  endproperty
  a_null_hold: assert property (p_null_hold)
    else $error("null queue advanced a read pointer");

  property p_mismatch;
    ce && s_qstrobe && !id_match && phase == PH_IDLE |=>
      $stable(pend_q) && $stable(pend_null) && phase == PH_IDLE;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("selection changed on identity mismatch");

  property p_drive;
    !read_data_oe_n |-> !s_ren_n && !s_oe_n && selected && !cur_null;
  endproperty
  a_drive: assert property (p_drive)
    else $error("read data driven while not enabled");
endmodule

// ===== sim/queue_reader_model.sv
`timescale 1ns/1ps
module queue_reader_model (
  input wire logic clk,
  input wire logic program_done_out_n,
  output logic read_en_n,
  output logic out_enable_n,
  output logic queue_select_strobe,
  output logic flag_sector_strobe,
  output logic [7:0] read_address_bus,
  output logic program_enable_in_n
);
  // Idle pins, chain input enabled from the start
  initial begin
    read_en_n = 1'b1;
    out_enable_n = 1'b0;
    queue_select_strobe = 1'b0;
    flag_sector_strobe = 1'b0;
    read_address_bus = 8'h00;
    program_enable_in_n = 1'b0;
  end

  // Queue change, one strobed cycle
  task automatic sel_queue(input logic [7:0] a);
    for (int i = 0; i < 200 && program_done_out_n !== 1'b0; i++) @(posedge clk);
    @(posedge clk);
    queue_select_strobe <= 1'b1;
    read_address_bus <= a;
    @(posedge clk);
    // strobe only for the change cycle
    queue_select_strobe <= 1'b0;
    read_address_bus <= ~a;
  endtask

  // Flag sector change, one strobed cycle
  task automatic sel_sector(input logic [7:0] a);
    @(posedge clk);
    flag_sector_strobe <= 1'b1;
    read_address_bus <= a;
    @(posedge clk);
    flag_sector_strobe <= 1'b0;
    read_address_bus <= ~a;
  endtask

  // Read enable low for n cycles
  task automatic pop(input int n);
    @(posedge clk);
    read_en_n <= 1'b0;
    repeat (n) @(posedge clk);
    read_en_n <= 1'b1;
  endtask

  // Output enable and chain input levels
  task automatic set_pins(input logic oe_n, input logic chain_n);
    @(posedge clk);
    out_enable_n <= oe_n;
    program_enable_in_n <= chain_n;
  endtask

  // Read enable held at a level
  task automatic hold_read(input logic v);
    @(posedge clk);
    read_en_n <= v;
  endtask
endmodule

// ===== sim/tb_multi_queue_read_port.sv
`timescale 1ns/1ps
module tb_multi_queue_read_port;
  import mq_read_pkg::*;
  logic clk, rst_n, ce, expansion_in, write_valid, write_ready;
  logic read_en_n, out_enable_n, queue_select_strobe, flag_sector_strobe, program_enable_in_n;
  logic [7:0] read_address_bus, sector_status_bus_n;
  logic [3:0] write_queue, avs_address;
  logic [35:0] write_data, read_data;
  logic read_data_oe_n, almost_empty_flag_n, packet_ready_flag_n, output_valid_flag_n;
  logic flag_poll_sync, expansion_out, program_done_out_n, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int n_mismatch, n_compared, n_hi;
  logic seen;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  multi_queue_read_port #(.DEPTH_LOG2(3)) DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce), .read_en_n(read_en_n), .out_enable_n(out_enable_n),
    .queue_select_strobe(queue_select_strobe), .flag_sector_strobe(flag_sector_strobe),
    .read_address_bus(read_address_bus), .program_enable_in_n(program_enable_in_n),
    .expansion_in(expansion_in), .read_data(read_data), .read_data_oe_n(read_data_oe_n),
    .almost_empty_flag_n(almost_empty_flag_n), .packet_ready_flag_n(packet_ready_flag_n),
    .output_valid_flag_n(output_valid_flag_n), .sector_status_bus_n(sector_status_bus_n),
    .flag_poll_sync(flag_poll_sync), .expansion_out(expansion_out),
    .program_done_out_n(program_done_out_n), .write_valid(write_valid),
    .write_queue(write_queue), .write_data(write_data), .write_ready(write_ready),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  queue_reader_model ctl (.clk(clk), .program_done_out_n(program_done_out_n),
    .read_en_n(read_en_n), .out_enable_n(out_enable_n),
    .queue_select_strobe(queue_select_strobe), .flag_sector_strobe(flag_sector_strobe),
    .read_address_bus(read_address_bus), .program_enable_in_n(program_enable_in_n));

  // Compare and count
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Covers synchroniser plus the two-edge queue change
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Avalon write, held until waitrequest low
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  // Avalon read, data taken at the answering edge
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Write port word, valid kept up between words
  task automatic put(input logic [3:0] q, input logic [35:0] d);
    write_valid <= 1'b1;
    write_queue <= q;
    write_data <= d;
    do @(posedge clk); while (write_ready !== 1'b1);
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    expansion_in = 1'b0;
    write_valid = 1'b0;
    write_queue = 4'h0;
    write_data = '0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    chk("status bus in reset", 36'hff, 36'(sector_status_bus_n));
    chk("valid flag in reset", 36'h1, 36'(output_valid_flag_n));
    rst_n <= 1'b1;
    bus_rd(OFS_THRESH, rd);
    chk("thresh", 36'h0402, 36'(rd));
    bus_rd(4'hc, rd);
    chk("unmapped read", 36'h0, 36'(rd));
    bus_wr(OFS_CTRL, 32'h10);
    bus_rd(OFS_CTRL, rd);
    chk("ctrl", 36'h10, 36'(rd));
    settle();
    chk("program done", 36'h0, 36'(program_done_out_n));
    for (int i = 0; i < 3; i++) begin
      put(4'h3, 36'h0a0 + 36'(i));
      put(4'h5, 36'h0b0 + 36'(i));
      put(4'h9, 36'h0e0 + 36'(i));
    end
    put(4'h7, 36'h0d0);
    write_valid <= 1'b0;
    settle();
    ctl.sel_queue(8'h03);
    settle();
    chk("q3 head", 36'h0a0, read_data);
    chk("valid flag", 36'h0, 36'(output_valid_flag_n));
    chk("expansion out", 36'h1, 36'(expansion_out));
    bus_rd(OFS_STATUS, rd);
    chk("status q3", 36'h32, 36'(rd & 32'hf6));
    ctl.pop(1);
    settle();
    chk("q3 next", 36'h0a1, read_data);
    ce <= 1'b0;
    ctl.pop(1);
    settle();
    chk("frozen output", 36'h0a1, read_data);
    ce <= 1'b1;
    seen = 1'b0;
    fork
      ctl.sel_queue(8'h05);
      repeat (10) begin
        @(posedge clk);
        if (read_data === 36'h0a2) seen = 1'b1;
      end
    join
    chk("old queue word", 36'h1, 36'(seen));
    settle();
    chk("q5 head", 36'h0b0, read_data);
    ctl.sel_queue(8'h10);
    settle();
    chk("null valid", 36'h1, 36'(output_valid_flag_n));
    chk("null packet ready", 36'h1, 36'(packet_ready_flag_n));
    chk("null expansion", 36'h0, 36'(expansion_out));
    ctl.pop(3);
    settle();
    ctl.sel_queue(8'h05);
    settle();
    chk("q5 after null", 36'h0b2, read_data);
    ctl.sel_queue(8'h07);
    settle();
    chk("q7 head", 36'h0d0, read_data);
    chk("almost empty", 36'h0, 36'(almost_empty_flag_n));
    chk("packet ready", 36'h1, 36'(packet_ready_flag_n));
    ctl.sel_queue(8'h29);
    settle();
    chk("foreign select", 36'h0d0, read_data);
    bus_rd(OFS_STATUS, rd);
    chk("status q7", 36'h72, 36'(rd & 32'hf6));
    ctl.sel_sector(8'h1f);
    settle();
    chk("sector 1", 36'h02, 36'(sector_status_bus_n));
    ctl.sel_sector(8'h1e);
    settle();
    chk("sector 0", 36'h00, 36'(sector_status_bus_n));
    ctl.sel_sector(8'h3f);
    settle();
    chk("foreign sector", 36'h00, 36'(sector_status_bus_n));
    bus_wr(OFS_CTRL, 32'h11);
    settle();
    n_hi = 0;
    repeat (6) begin
      @(posedge clk);
      if (flag_poll_sync === 1'b1) n_hi++;
      chk("polled bus", flag_poll_sync ? 36'h0 : 36'h2, 36'(sector_status_bus_n));
    end
    chk("sync count", 36'h3, 36'(n_hi));
    ctl.sel_queue(8'h09);
    settle();
    ctl.hold_read(1'b0);
    repeat (4) @(posedge clk);
    chk("data drive", 36'h0, 36'(read_data_oe_n));
    ctl.set_pins(1'b1, 1'b1);
    repeat (4) @(posedge clk);
    chk("output disabled", 36'h1, 36'(read_data_oe_n));
    chk("chain follow", 36'h1, 36'(program_done_out_n));
    ctl.set_pins(1'b0, 1'b0);
    expansion_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk("drive yielded", 36'h1, 36'(read_data_oe_n));
    ctl.hold_read(1'b1);
    stop_test();
  end
endmodule
